// >>> port_edge_change_detector.v
// Port edge change detector with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "edge_detect_defs.vh"
module port_edge_change_detector #(
   parameter PINS = `PIN_COUNT
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire nrst_i,
   // Port pins
   input wire [PINS-1:0] first_port_pin_i,
   // AXI4-Lite write address
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Interrupt and combined flag
   output wire combined_change_irq_flag_o,
   output wire irq_o
);
   // =====================================================================
   // Register map decode
   // Register slots in one-hot order; the decoder returns one bit per slot
   localparam SLOT_RISE = 0;
   localparam SLOT_FALL = 1;
   localparam SLOT_FLAGS = 2;
   localparam SLOT_STATUS = 3;
   localparam SLOT_CLEAR = 4;
   localparam SLOT_ENABLE = 5;
   localparam SLOTS = 6;

   // One-hot register select from a byte address; all zero when unmapped
   function [SLOTS-1:0] reg_select;
      input [4:0] a;
      begin
         reg_select = {SLOTS{1'b0}};
         case (a)
            `OFS_RISE_EN: reg_select[SLOT_RISE] = 1'b1;
            `OFS_FALL_EN: reg_select[SLOT_FALL] = 1'b1;
            `OFS_FLAGS: reg_select[SLOT_FLAGS] = 1'b1;
            `OFS_IRQ_STATUS: reg_select[SLOT_STATUS] = 1'b1;
            `OFS_IRQ_CLEAR: reg_select[SLOT_CLEAR] = 1'b1;
            `OFS_IRQ_ENABLE: reg_select[SLOT_ENABLE] = 1'b1;
            default: reg_select = {SLOTS{1'b0}};
         endcase
      end
   endfunction

   // Response code; the write-only clear register refuses reads
   function [1:0] access_resp;
      input [SLOTS-1:0] sel;
      input is_read;
      begin
         if (sel == {SLOTS{1'b0}}) begin
            access_resp = `RESP_SLVERR;
         end else if (is_read && sel[SLOT_CLEAR]) begin
            access_resp = `RESP_SLVERR;
         end else begin
            access_resp = `RESP_OKAY;
         end
      end
   endfunction

   // Register contents
   reg [PINS-1:0] rise_detect_enable;
   reg [PINS-1:0] fall_detect_enable;
   wire [PINS-1:0] pin_change_flag;
   wire [PINS-1:0] pin_event;
   reg irq_status;
   reg irq_enable;
   // Write holding registers
   reg aw_held;
   reg [4:0] aw_addr;
   reg w_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   // Handshakes, decoded strobes and read path
   wire aw_take;
   wire w_take;
   wire ar_take;
   wire b_done;
   wire r_done;
   wire wr_fire;
   wire wr_low_lane;
   wire [SLOTS-1:0] wr_sel;
   wire [SLOTS-1:0] rd_sel;
   wire wr_rise;
   wire wr_fall;
   wire flag_wr;
   wire status_clear;
   wire wr_enable;
   wire any_event;
   reg [31:0] next_rdata;

   // =====================================================================
   // Channel handshakes: an item moves when its valid and ready are both high
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign b_done = s_axi_bvalid & s_axi_bready;
   assign r_done = s_axi_rvalid & s_axi_rready;

   // =====================================================================
   // AXI4-Lite write channel: capture address and data in either order
   // Each item is refused while it is held or while the answer waits
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign wr_fire = aw_held & w_held & ~s_axi_bvalid;

   // Write address holding register
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aw_held <= 1'b0;
         aw_addr <= 5'h00;
      end else if (aw_take) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   // Write data holding register
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else if (w_take) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   // Write response: one answer per completed write, held until taken
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= access_resp(wr_sel, 1'b0);
      end else if (b_done) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // =====================================================================
   // Register write strobes; only the low byte lane carries fields
   assign wr_sel = reg_select(aw_addr);
   assign wr_low_lane = wr_fire & w_strb[0];
   assign wr_rise = wr_low_lane & wr_sel[SLOT_RISE];
   assign wr_fall = wr_low_lane & wr_sel[SLOT_FALL];
   assign flag_wr = wr_low_lane & wr_sel[SLOT_FLAGS];
   assign status_clear = wr_low_lane & wr_sel[SLOT_CLEAR] & w_data[`IRQ_BIT_CHANGE];
   assign wr_enable = wr_low_lane & wr_sel[SLOT_ENABLE];

   // Rising-edge enables, one bit per pin
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rise_detect_enable <= {PINS{1'b0}};
      end else if (wr_rise) begin
         rise_detect_enable <= w_data[PINS-1:0];
      end
   end

   // Falling-edge enables, one bit per pin
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fall_detect_enable <= {PINS{1'b0}};
      end else if (wr_fall) begin
         fall_detect_enable <= w_data[PINS-1:0];
      end
   end

   // Interrupt enable bit
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_enable <= 1'b0;
      end else if (wr_enable) begin
         irq_enable <= w_data[`IRQ_BIT_CHANGE];
      end
   end

   // =====================================================================
   // Per-pin detector cells
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin
         edge_cell u_cell (
            .sys_clk_i(sys_clk_i),
            .nrst_i(nrst_i),
            .pin_i(first_port_pin_i[gi]),
            .rise_en_i(rise_detect_enable[gi]),
            .fall_en_i(fall_detect_enable[gi]),
            .wr_i(flag_wr),
            .wdata_i(w_data[gi]),
            .event_o(pin_event[gi]),
            .flag_o(pin_change_flag[gi])
         );
      end
   endgenerate

   // =====================================================================
   // Combined flag and sticky interrupt status
   assign any_event = |pin_event;
   assign combined_change_irq_flag_o = |pin_change_flag;

   // Status bit: a new edge beats a clear in the same cycle so no event is lost
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_status <= 1'b0;
      end else if (any_event) begin
         irq_status <= 1'b1;
      end else if (status_clear) begin
         irq_status <= 1'b0;
      end
   end

   // Level interrupt while the enabled status bit is set
   assign irq_o = irq_status & irq_enable;

   // =====================================================================
   // AXI4-Lite read channel
   // A new address is refused while the previous answer waits
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_sel = reg_select(s_axi_araddr);

   // Read mux; bits above the fields stay zero
   always @* begin
      next_rdata = 32'h00000000;
      if (rd_sel[SLOT_RISE]) begin
         next_rdata[PINS-1:0] = rise_detect_enable;
      end
      if (rd_sel[SLOT_FALL]) begin
         next_rdata[PINS-1:0] = fall_detect_enable;
      end
      if (rd_sel[SLOT_FLAGS]) begin
         next_rdata[PINS-1:0] = pin_change_flag;
      end
      if (rd_sel[SLOT_STATUS]) begin
         next_rdata[`IRQ_BIT_CHANGE] = irq_status;
      end
      if (rd_sel[SLOT_ENABLE]) begin
         next_rdata[`IRQ_BIT_CHANGE] = irq_enable;
      end
   end

   // Read answer valid, held until taken
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_rvalid <= 1'b0;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
      end else if (r_done) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Read data and response, captured when the address is taken
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= access_resp(rd_sel, 1'b1);
      end
   end
endmodule // port_edge_change_detector
`default_nettype wire

// >>> edge_detect_defs.vh
// Register offsets, field layout, reset values for the port edge change detector
`ifndef EDGE_DETECT_DEFS_VH
`define EDGE_DETECT_DEFS_VH
// =====================================================================
// Register byte offsets
`define OFS_RISE_EN 5'h00
`define OFS_FALL_EN 5'h04
`define OFS_FLAGS 5'h08
`define OFS_IRQ_STATUS 5'h0c
`define OFS_IRQ_CLEAR 5'h10
`define OFS_IRQ_ENABLE 5'h14
// =====================================================================
// Field layout and reset values
`define PIN_COUNT 6
`define REG_WIDTH 8
`define REG_RESET 8'h00
`define IRQ_BIT_CHANGE 0
// =====================================================================
// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> edge_cell.v
// Per-pin edge detector cell with sticky change flag
`timescale 1ns/1ps
`default_nettype none
module edge_cell (
   // Clock and reset
   input wire sys_clk_i,
   input wire nrst_i,
   // Pin and controls
   input wire pin_i,
   input wire rise_en_i,
   input wire fall_en_i,
   input wire wr_i,
   input wire wdata_i,
   // Results
   output wire event_o,
   output reg flag_o
);
   reg pin_q;
   wire rise;
   wire fall;

   // Edge detection against last sampled level
   assign rise = pin_i & ~pin_q;
   assign fall = ~pin_i & pin_q;
   assign event_o = (rise & rise_en_i) | (fall & fall_en_i);

   // Previous pin level
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin_i;
      end
   end

   // Sticky flag: hardware set wins over software write
   always @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flag_o <= 1'b0;
      end else if (event_o) begin
         flag_o <= 1'b1;
      end else if (wr_i) begin
         flag_o <= wdata_i;
      end
   end
endmodule // edge_cell
`default_nettype wire

// >>> edge_detect_checker_assertions.sv
// Port-level checker for the edge change detector
`timescale 1ns/1ps
`default_nettype none
module edge_detect_checker #(
   parameter PINS = 6
) (
   // Clock, reset and pins
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [PINS-1:0] first_port_pin_i,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic [1:0] s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   // Flags
   input wire logic combined_change_irq_flag_o,
   input wire logic irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   // =====
   // Assertions
   chk_reset_clear: assert property ($rose(nrst_i) |-> !combined_change_irq_flag_o && !irq_o)
      else $error("flag high after reset");
   chk_flag_cause: assert property ($rose(combined_change_irq_flag_o) |->
      $past(first_port_pin_i) != $past(first_port_pin_i, 2) || $past(first_port_pin_i, 2) !=
      $past(first_port_pin_i, 3) || s_axi_bvalid || $past(s_axi_bvalid)) else $error("flag set without cause");
   chk_flag_sticky: assert property ($fell(combined_change_irq_flag_o) |-> s_axi_bvalid ||
      $past(s_axi_bvalid) || $past(s_axi_wvalid) || $past(s_axi_awvalid)) else $error("flag lost without write");
   chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
      else $error("upper read bits set");
   chk_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
   chk_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property ($rose(irq_o));
   cover property ($fell(combined_change_irq_flag_o));
endmodule // edge_detect_checker
bind port_edge_change_detector edge_detect_checker #(.PINS(PINS)) edge_detect_checker_i (.sys_clk_i, .nrst_i,
   .first_port_pin_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
   .s_axi_rresp, .s_axi_rdata, .combined_change_irq_flag_o, .irq_o);
`default_nettype wire

// >>> pin_stimulus_model.sv
// Outside logic that drives the port pins
`timescale 1ns/1ps
`default_nettype none
module pin_stimulus_model (
   // Clock
   input wire sys_clk_i,
   // Pin levels
   output logic [5:0] pin_level_o
);
   initial pin_level_o = 6'h00;
   // Moves the pins just after a clock edge
   task automatic drive(input logic [5:0] level);
      @(posedge sys_clk_i);
      pin_level_o <= level;
   endtask
endmodule // pin_stimulus_model
`default_nettype wire

// >>> test_port_edge_change_detector.sv
// Testbench for the port edge change detector
`timescale 1ns/1ps
`default_nettype none
`include "edge_detect_defs.vh"
module test_port_edge_change_detector;
   logic sys_clk_i, nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, combined_change_irq_flag_o, irq_o;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [5:0] pins;
   int fails, checks;
   port_edge_change_detector port_edge_change_detector_i (.sys_clk_i, .nrst_i, .first_port_pin_i(pins),
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .combined_change_irq_flag_o, .irq_o);
   pin_stimulus_model pin_stimulus_model_i (.sys_clk_i, .pin_level_o(pins));
   // =====
   // Tasks
   task automatic check(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Bus access; handshakes are judged on the falling edge before the taking edge
   task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ta, tw, tb;
      logic [1:0] resp;
      logic [31:0] dat;
      @(posedge sys_clk_i);
      if (wr) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      for (int n = 0; n < 50; n++) begin
         @(negedge sys_clk_i);
         ta = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = wr ? s_axi_bvalid : s_axi_rvalid;
         resp = wr ? s_axi_bresp : s_axi_rresp;
         dat = s_axi_rdata;
         @(posedge sys_clk_i);
         if (ta && wr) s_axi_awvalid <= 1'b0;
         if (ta && !wr) s_axi_arvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) begin
            if (wr) s_axi_bready <= 1'b0;
            else s_axi_rready <= 1'b0;
            check("resp", resp, r);
            if (!wr) check("rdata", dat, d);
            return;
         end
      end
      fails++;
      complete_run();
   endtask
   task automatic outs(input logic comb, irq);
      @(negedge sys_clk_i);
      check("combined", combined_change_irq_flag_o, comb);
      check("irq", irq_o, irq);
   endtask
   // =====
   // Clock and main sequence
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      {nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
      s_axi_wstrb = 4'hf;
      fails = 0;
      checks = 0;
      repeat (10) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      for (int i = 0; i < 24; i += 4) if (i != 16) access(0, 5'(i), 0, `RESP_OKAY);
      access(1, `OFS_RISE_EN, 32'hff, `RESP_OKAY);
      access(0, `OFS_RISE_EN, 32'h3f, `RESP_OKAY);
      access(1, `OFS_FALL_EN, 32'hffffffff, `RESP_OKAY);
      access(0, `OFS_FALL_EN, 32'h3f, `RESP_OKAY);
      access(1, `OFS_RISE_EN, 32'h15, `RESP_OKAY);
      access(1, `OFS_FALL_EN, 32'h2a, `RESP_OKAY);
      access(1, 5'h14, 32'h1, `RESP_OKAY);
      pin_stimulus_model_i.drive(6'h3f);
      access(0, `OFS_FLAGS, 32'h15, `RESP_OKAY);
      outs(1, 1);
      access(0, `OFS_IRQ_STATUS, 32'h1, `RESP_OKAY);
      access(1, 5'h14, 32'h0, `RESP_OKAY);
      outs(1, 0);
      access(1, 5'h14, 32'h1, `RESP_OKAY);
      access(1, `OFS_FLAGS, 32'h0, `RESP_OKAY);
      access(0, `OFS_FLAGS, 32'h0, `RESP_OKAY);
      outs(0, 1);
      access(1, 5'h10, 32'h1, `RESP_OKAY);
      outs(0, 0);
      pin_stimulus_model_i.drive(6'h00);
      access(0, `OFS_FLAGS, 32'h2a, `RESP_OKAY);
      outs(1, 1);
      // Clear all flags while a rising edge on pin 0 lands in the same cycle as the clear write
      fork
         access(1, `OFS_FLAGS, 32'h0, `RESP_OKAY);
         begin
            @(posedge sys_clk_i);
            pin_stimulus_model_i.drive(6'h01);
         end
      join
      access(0, `OFS_FLAGS, 32'h01, `RESP_OKAY);
      access(1, 5'h18, 32'h3f, `RESP_SLVERR);
      access(0, 5'h18, 32'h0, `RESP_SLVERR);
      access(0, 5'h10, 32'h0, `RESP_SLVERR);
      @(posedge sys_clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      access(0, `OFS_FLAGS, 32'h0, `RESP_OKAY);
      access(0, `OFS_FALL_EN, 32'h0, `RESP_OKAY);
      outs(0, 0);
      complete_run();
   end
endmodule // test_port_edge_change_detector
`default_nettype wire
